// ### src/dsfc_ctrl.v
// Control bank for multichip sync, frame pulse reset, FIFO level setup and device identifier.
`timescale 1ns/1ps
`include "dsfc_map.vh"
module dsfc_ctrl #(
  parameter [7:0] DEVICE_CODE = 8'h5c // Arbitrary identifier value.
) (
  input  wire       clk_sys,
  input  wire       nrst,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  input  wire       regRdEn,
  output reg  [7:0] regRdData,
  output reg        regRdValid,
  input  wire       syncClkIn,
  input  wire       framePulse,
  output wire       syncSampled,
  output reg        fifoResetPulse,
  output reg        ncoResetPulse,
  output reg  [2:0] rdPtrOffsetInt,
  output reg  [2:0] rdPtrOffsetFrac,
  output wire [7:0] irqSetupCode
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [7:0] irqSetup_r;
  reg  [7:0] alignCtrl_r;
  reg  [7:0] frameCtrl_r;
  reg  [7:0] fifoSpace_r;
  reg        rstReq_r;
  reg        rstAck_r;
  reg        armed_r;
  reg        reqPending_r;

  wire       contMode;
  wire [1:0] target;
  wire       frameAct;
  wire       frameFifo;
  wire       frameNco;
  wire       reqStart;
  wire       fifoRstNow;
  wire       wrIrq;
  wire       wrAlign;
  wire       wrFrame;
  wire       wrSpace;
  wire       wrFifoCtrl;

  // Decodes a write strobe for one offset.
  function wrHit;
    input [7:0] addr;
    input [7:0] offset;
    input       en;
    begin
      wrHit = en & (addr == offset);
    end
  endfunction

  assign wrIrq      = wrHit(regAddr, `DSFC_ADDR_IRQ_SETUP, regWrEn);
  assign wrAlign    = wrHit(regAddr, `DSFC_ADDR_ALIGN_CTRL, regWrEn);
  assign wrFrame    = wrHit(regAddr, `DSFC_ADDR_FRAME_CTRL, regWrEn);
  assign wrSpace    = wrHit(regAddr, `DSFC_ADDR_FIFO_SPACE, regWrEn);
  assign wrFifoCtrl = wrHit(regAddr, `DSFC_ADDR_FIFO_CTRL, regWrEn);

  // The interrupt setup byte is passed to the interrupt logic unchanged.
  assign irqSetupCode = irqSetup_r;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Reserved bits are cleared on each write; the frame control reset value 8'h12 leaves bit 4 set.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      irqSetup_r  <= `DSFC_RST_IRQ_SETUP;
      alignCtrl_r <= `DSFC_RST_ALIGN_CTRL;
      frameCtrl_r <= `DSFC_RST_FRAME_CTRL;
      fifoSpace_r <= `DSFC_RST_FIFO_SPACE;
    end else begin
      if (wrIrq) begin
        irqSetup_r <= regWrData;
      end
      if (wrAlign) begin
        alignCtrl_r <= regWrData & 8'h03;
      end
      if (wrFrame) begin
        frameCtrl_r <= regWrData & 8'h0f;
      end
      if (wrSpace) begin
        fifoSpace_r <= regWrData & 8'h77;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync clock sampling
  // ----------------------------------------------------------------
  dsfc_sync_sample u_sync (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .syncClkIn   (syncClkIn),
    .edgeRising  (alignCtrl_r[`DSFC_BIT_SYNC_EDGE]),
    .syncEnable  (alignCtrl_r[`DSFC_BIT_SYNC_EN]),
    .syncSampled (syncSampled)
  );

  // ----------------------------------------------------------------
  // Frame pulse reset
  // ----------------------------------------------------------------
  assign contMode  = frameCtrl_r[`DSFC_BIT_CONT];
  assign target    = frameCtrl_r[`DSFC_TGT_HI:`DSFC_TGT_LO];
  assign frameAct  = framePulse & (contMode | armed_r);
  assign frameFifo = frameAct & ((target == `DSFC_TGT_FIFO) | (target == `DSFC_TGT_BOTH));
  assign frameNco  = frameAct & ((target == `DSFC_TGT_NCO) | (target == `DSFC_TGT_BOTH));

  // The one-shot arm flag; a re-arm write in the same cycle as a pulse wins.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      armed_r <= 1'b1;
    end else if (wrFrame && regWrData[`DSFC_BIT_ARM]) begin
      armed_r <= 1'b1;
    end else if (frameAct && !contMode) begin
      armed_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software FIFO reset request and acknowledge
  // ----------------------------------------------------------------
  assign reqStart   = wrFifoCtrl & regWrData[`DSFC_BIT_RST_REQ] & ~rstReq_r;
  assign fifoRstNow = frameFifo | reqPending_r;

  // Request bit, pending flag and acknowledge; ack is dropped when the request is withdrawn.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      rstReq_r     <= 1'b0;
      reqPending_r <= 1'b0;
      rstAck_r     <= 1'b0;
    end else begin
      if (wrFifoCtrl) begin
        rstReq_r <= regWrData[`DSFC_BIT_RST_REQ];
      end
      reqPending_r <= reqStart;
      if (reqPending_r) begin
        rstAck_r <= 1'b1;
      end else if (wrFifoCtrl && !regWrData[`DSFC_BIT_RST_REQ]) begin
        rstAck_r <= 1'b0;
      end
    end
  end

  // Reset pulses and pointer repositioning on every FIFO reset.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      fifoResetPulse  <= 1'b0;
      ncoResetPulse   <= 1'b0;
      rdPtrOffsetInt  <= 3'h0;
      rdPtrOffsetFrac <= 3'h0;
    end else begin
      fifoResetPulse <= fifoRstNow;
      ncoResetPulse  <= frameNco;
      if (fifoRstNow) begin
        rdPtrOffsetInt  <= fifoSpace_r[`DSFC_INT_HI:`DSFC_INT_LO];
        rdPtrOffsetFrac <= fifoSpace_r[`DSFC_FRAC_HI:`DSFC_FRAC_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Registered read data; unmapped offsets read as zero.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (!regRdEn) begin
        regRdData <= regRdData;
      end else if (regAddr == `DSFC_ADDR_DEV_ID) begin
        regRdData <= DEVICE_CODE;
      end else if (regAddr == `DSFC_ADDR_IRQ_SETUP) begin
        regRdData <= irqSetup_r;
      end else if (regAddr == `DSFC_ADDR_ALIGN_CTRL) begin
        regRdData <= alignCtrl_r;
      end else if (regAddr == `DSFC_ADDR_FRAME_CTRL) begin
        regRdData <= frameCtrl_r;
      end else if (regAddr == `DSFC_ADDR_FIFO_SPACE) begin
        regRdData <= fifoSpace_r;
      end else if (regAddr == `DSFC_ADDR_FIFO_RDBK) begin
        regRdData <= {1'b0, rdPtrOffsetInt, 1'b0, rdPtrOffsetFrac};
      end else if (regAddr == `DSFC_ADDR_FIFO_CTRL) begin
        regRdData <= {6'h00, rstAck_r, rstReq_r};
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

endmodule

// ### src/dsfc_map.vh
// Register offsets, field positions, reset values and codes of the sync, frame reset and FIFO level control bank.
// Functional notes
// - Sync clock edge chosen by select bit; enable
// - One-shot mode acts on first frame only
// - Continuous mode acts on every frame pulse
// - Arm bit write re-arms one-shot frame reset
// - Target field picks FIFO, NCO, both, none
// - Integer level bits 6:4 in data units
// - Defaults: integer level 4, fraction 0
// - Fractional level bits 2:0 in clock cycles
// - Interrupt setup byte: 0x00 test, 0x01 normal
// - Read-only 8-bit device identifier register
// - Software FIFO reset request with acknowledge bit
`ifndef DSFC_MAP_VH
`define DSFC_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DSFC_ADDR_DEV_ID     8'h1f
`define DSFC_ADDR_IRQ_SETUP  8'h20
`define DSFC_ADDR_ALIGN_CTRL 8'h21
`define DSFC_ADDR_FRAME_CTRL 8'h22
`define DSFC_ADDR_FIFO_SPACE 8'h23
`define DSFC_ADDR_FIFO_RDBK  8'h24
`define DSFC_ADDR_FIFO_CTRL  8'h25

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSFC_RST_IRQ_SETUP  8'h00
`define DSFC_RST_ALIGN_CTRL 8'h00
`define DSFC_RST_FRAME_CTRL 8'h12
`define DSFC_RST_FIFO_SPACE 8'h40
`define DSFC_RST_FIFO_CTRL  8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSFC_BIT_SYNC_EN    0
`define DSFC_BIT_SYNC_EDGE  1
`define DSFC_BIT_ARM        3
`define DSFC_BIT_CONT       2
`define DSFC_TGT_HI         1
`define DSFC_TGT_LO         0
`define DSFC_INT_HI         6
`define DSFC_INT_LO         4
`define DSFC_FRAC_HI        2
`define DSFC_FRAC_LO        0
`define DSFC_BIT_RST_REQ    0
`define DSFC_BIT_RST_ACK    1

// ----------------------------------------------------------------
// Frame reset target codes and interrupt setup codes
// ----------------------------------------------------------------
`define DSFC_TGT_FIFO       2'h0
`define DSFC_TGT_NCO        2'h1
`define DSFC_TGT_BOTH       2'h2
`define DSFC_TGT_NONE       2'h3
`define DSFC_IRQ_TEST       8'h00
`define DSFC_IRQ_NORMAL     8'h01

`endif

// ### src/dsfc_sync_sample.v
// Sync clock sampler that picks the rising or falling converter clock edge.
`timescale 1ns/1ps
module dsfc_sync_sample (
  input  wire clk_sys,
  input  wire nrst,
  input  wire syncClkIn,
  input  wire edgeRising,
  input  wire syncEnable,
  output reg  syncSampled
);

  reg riseSample_r;
  reg fallSample_r;

  // Rising-edge capture of the sync clock.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      riseSample_r <= 1'b0;
    end else begin
      riseSample_r <= syncClkIn;
    end
  end

  // Falling-edge capture; it is retimed below, so it only sees half a period of path.
  always @(negedge clk_sys) begin
    if (!nrst) begin
      fallSample_r <= 1'b0;
    end else begin
      fallSample_r <= syncClkIn;
    end
  end

  // Select the sampling edge and gate with the enable.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      syncSampled <= 1'b0;
    end else if (!syncEnable) begin
      syncSampled <= 1'b0;
    end else begin
      syncSampled <= edgeRising ? riseSample_r : fallSample_r;
    end
  end

endmodule

// ### test/dsfc_ctrl_assertions.sv
// Assertion checker bound to the control bank ports.
`timescale 1ns/1ps
module dsfc_ctrl_checker #(
  parameter [7:0] DEVICE_CODE = 8'h5c // Arbitrary identifier value.
) (
  input wire       clk_sys,
  input wire       nrst,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrEn,
  input wire       regRdEn,
  input wire [7:0] regRdData,
  input wire       regRdValid,
  input wire       framePulse,
  input wire       syncClkIn,
  input wire       syncSampled,
  input wire       fifoResetPulse,
  input wire       ncoResetPulse,
  input wire [2:0] rdPtrOffsetInt,
  input wire [2:0] rdPtrOffsetFrac,
  input wire [7:0] irqSetupCode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Read answers, identifier and readback holding.
  property p_rd_ans; regRdEn |=> regRdValid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
  property p_rd_hold; !regRdValid |-> $stable(regRdData); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_dev_id; regRdEn && regAddr == 8'h1f |=> regRdData == DEVICE_CODE; endproperty
  a_dev_id: assert property (p_dev_id) else $error("identifier wrong");
  // Reset pulses need a cause, offsets move only on a FIFO reset.
  property p_nco_cause; ncoResetPulse |-> $past(framePulse); endproperty
  a_nco_cause: assert property (p_nco_cause) else $error("stray nco reset");
  property p_fifo_cause; fifoResetPulse |-> $past(framePulse) || $past(regWrEn, 2); endproperty
  a_fifo_cause: assert property (p_fifo_cause) else $error("stray fifo reset");
  property p_int_hold; !fifoResetPulse |-> $stable(rdPtrOffsetInt); endproperty
  a_int_hold: assert property (p_int_hold) else $error("integer offset moved");
  property p_frac_hold; !fifoResetPulse |-> $stable(rdPtrOffsetFrac); endproperty
  a_frac_hold: assert property (p_frac_hold) else $error("fraction offset moved");
  property p_irq_wr; regWrEn && regAddr == 8'h20 |=> irqSetupCode == $past(regWrData); endproperty
  a_irq_wr: assert property (p_irq_wr) else $error("irq setup not written");
  // A high sync sample needs a high sync clock one or two edges earlier.
  property p_sync_src; syncSampled |-> $past(syncClkIn) || $past(syncClkIn, 2); endproperty
  a_sync_src: assert property (p_sync_src) else $error("sync sample without source");
endmodule
bind dsfc_ctrl dsfc_ctrl_checker #(.DEVICE_CODE(DEVICE_CODE)) dsfc_ctrl_checker_i (.clk_sys, .nrst, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .regRdData, .regRdValid, .framePulse, .syncClkIn, .syncSampled,
  .fifoResetPulse, .ncoResetPulse,
  .rdPtrOffsetInt, .rdPtrOffsetFrac, .irqSetupCode);

// ### test/dsfc_pulse_src.sv
// Model of the sync clock and frame pulse source.
`timescale 1ns/1ps
module dsfc_pulse_src (
  input  wire  clk_sys,
  input  wire  nrst,
  input  wire  fireReq,
  output logic syncClkIn,
  output logic framePulse
);
  logic [1:0] divCnt_r;
  // One frame pulse cycle per request cycle; sync clock toggles every third cycle.
  always @(posedge clk_sys) begin
    framePulse <= nrst && fireReq;
    divCnt_r   <= (nrst && divCnt_r != 2'h2) ? divCnt_r + 2'h1 : 2'h0;
    syncClkIn  <= nrst ? syncClkIn ^ (divCnt_r == 2'h2) : 1'b0;
  end
endmodule

// ### test/testbench.sv
// Self-checking bench for the sync, frame reset and FIFO level control bank.
`timescale 1ns/1ps
module testbench;
  localparam [7:0] DEV = 8'h3b; // Arbitrary identifier value.
  logic        clk_sys, nrst, regWrEn, regRdEn, fireReq, syncClkIn, framePulse;
  logic        regRdValid, syncSampled, fifoResetPulse, ncoResetPulse;
  logic [7:0]  regAddr, regWrData, regRdData, irqSetupCode;
  logic [2:0]  rdPtrOffsetInt, rdPtrOffsetFrac, curInt, curFrac;
  logic        syncChk = 1'b0;
  logic [1:0]  syncMode, syncHist;
  logic [31:0] seed = 32'h6e3c2c8d;
  logic [7:0]  rdQ[$], pulseQ[$];
  logic [15:0] rstTab[7] = '{16'h1f3b, 16'h2000, 16'h2100, 16'h2212, 16'h2340, 16'h2500, 16'h3000};
  int          fails, total_checks, i, t;
  dsfc_ctrl #(.DEVICE_CODE(DEV)) dsfc_ctrl_i (.clk_sys, .nrst, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .regRdValid, .syncClkIn, .framePulse, .syncSampled, .fifoResetPulse, .ncoResetPulse,
    .rdPtrOffsetInt, .rdPtrOffsetFrac, .irqSetupCode);
  dsfc_pulse_src dsfc_pulse_src_i (.clk_sys, .nrst, .fireReq, .syncClkIn, .framePulse);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmpRd(input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch regRdData expected %h seen %h", e, g);
    end
  endtask
  task automatic cmpPulse(input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch resetPulses expected %h seen %h", e, g);
    end
  endtask
  task automatic cmpSync(input logic e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch syncSampled expected %h seen %h", e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    rdQ.push_back(e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
  endtask
  // Holds the frame request for len cycles and notes expN resets of value e.
  task automatic fire(input logic [7:0] e, input int len, expN);
    repeat (expN) pulseQ.push_back(e);
    @(posedge clk_sys);
    fireReq <= 1'b1;
    repeat (len) @(posedge clk_sys);
    fireReq <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Clock at 250 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Results are compared against the oldest note as they appear.
  always @(negedge clk_sys) begin
    if (regRdValid === 1'b1) cmpRd(rdQ.size() ? rdQ.pop_front() : 8'hxx, regRdData);
    if (fifoResetPulse === 1'b1 || ncoResetPulse === 1'b1)
      cmpPulse(pulseQ.size() ? pulseQ.pop_front() : 8'hxx,
               {fifoResetPulse, ncoResetPulse, rdPtrOffsetInt, rdPtrOffsetFrac});
    if (syncChk) cmpSync(syncMode[0] ? (syncMode[1] ? syncHist[1] : syncHist[0]) : 1'b0, syncSampled);
  end
  // Sync clock history as sampled at each rising edge.
  always @(posedge clk_sys) syncHist <= {syncHist[0], syncClkIn};
  // Watchdog against a hung run.
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    {nrst, regWrEn, regRdEn, fireReq, regAddr, regWrData} = '0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (rstTab[i]) rd(rstTab[i][15:8], rstTab[i][7:0]);
    {curInt, curFrac} = 6'h20;
    fire(8'he0, 1, 1);
    fire(8'h00, 1, 0);
    // Every target code after re-arming, two back to back pulses, random levels.
    for (t = 0; t < 4; t++) begin
      seed = lfsr(seed);
      wr(8'h23, seed[7:0]);
      rd(8'h23, seed[7:0] & 8'h77);
      wr(8'h22, 8'h08 | t[7:0]);
      if (!t[0]) {curInt, curFrac} = {seed[6:4], seed[2:0]};
      fire({~t[0], t[0] ^ t[1], curInt, curFrac}, 2, t != 3);
    end
    {curInt, curFrac} = {seed[6:4], seed[2:0]};
    wr(8'h22, 8'h04);
    fire({2'b10, curInt, curFrac}, 3, 3);
    pulseQ.push_back({2'b10, curInt, curFrac});
    wr(8'h25, 8'h01);
    rd(8'h25, 8'h03);
    wr(8'h25, 8'h00);
    rd(8'h25, 8'h00);
    wr(8'h1f, 8'hff);
    rd(8'h1f, DEV);
    seed = lfsr(seed);
    wr(8'h20, seed[7:0]);
    rd(8'h20, seed[7:0]);
    wr(8'h21, 8'h03);
    rd(8'h21, 8'h03);
    // Every sync mode: off, falling edge, off with rising select, rising edge.
    for (t = 0; t < 4; t++) begin
      wr(8'h21, {6'h00, t[1:0]});
      @(posedge clk_sys);
      {syncChk, syncMode} = {1'b1, t[1:0]};
      repeat (12) @(posedge clk_sys);
      syncChk = 1'b0;
    end
    for (i = 0; i < 100 && (rdQ.size() || pulseQ.size()); i++) @(posedge clk_sys);
    if (i == 100) fails++;
    give_verdict();
  end
endmodule
